// ===== rtl/io_cfg_core.sv
`timescale 1ns/1ps
`include "io_cfg_regs.svh"
module io_cfg_core #(
  parameter int NPINS = 2,
  parameter int NBEAMS = 32,
  parameter int TEACH_MIN_CYC = (`CLK_HZ / 1000) * `TEACH_MIN_MS,
  parameter int TEACH_MAX_CYC = (`CLK_HZ / 1000) * `TEACH_MAX_MS,
  parameter int SEC_CYC = `CLK_HZ,
  parameter logic [31:0] PRODUCT_ID = 32'h0000_1234, // arbitrary value
  parameter logic [31:0] SERIAL_NO = 32'h0000_0001, // arbitrary value
  parameter logic [31:0] PRODUCT_NAME = 32'h4C43_0001 // arbitrary value
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_arst_n,
  // apb slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // measurement results
  input wire logic i_meas_strobe,
  input wire logic [NBEAMS-1:0] i_beams,
  input wire logic i_warn,
  input wire logic i_trig_evt,
  // switching pins
  input wire logic [NPINS-1:0] i_pin,
  output logic [NPINS-1:0] o_pin,
  output logic [NPINS-1:0] o_pin_oe,
  // pin events
  output logic [NPINS-1:0] o_teach_req,
  output logic [NPINS-1:0] o_trig_in,
  // control panel and display
  input wire logic i_button,
  output logic [1:0] o_disp_level,
  output logic o_disp_invert,
  output logic o_cfg_mode,
  output logic [2:0] o_language
);
  localparam int CFG_IDLE_S = `CFG_IDLE_MIN * 60;
  localparam int BURN_S = `BURN_MIN * 60;

  typedef struct packed {
    logic sinking;
    logic casc;
    lc_pkg::lang_t lang;
    lc_pkg::pin_func_t [NPINS-1:0] func;
    logic [NPINS-1:0] inv;
    logic [NPINS-1:0] area_or;
    logic [NPINS-1:0][10:0] b_start;
    logic [NPINS-1:0][10:0] b_end;
    logic [7:0] depth;
    lc_pkg::vis_t vis;
    logic [8:0] tu;
    logic rejected;
    logic [31:0] rdata;
    logic [NPINS-1:0] pin;
    logic [NPINS-1:0] pin_oe;
    logic [NPINS-1:0] lin_prev;
    logic [NPINS-1:0] trig_in;
    logic [31:0] sec_div;
    logic [8:0] idle_s;
    logic cfg;
    logic wake;
    logic [9:0] burn_s;
    logic img_inv;
    logic [1:0] dyn_lvl;
    logic [8:0] dyn_acc;
    logic [1:0] level;
  } core_t;

  // reset image of the state record
  function automatic core_t rst_val();
    core_t r;
    r = '0;
    r.lang = lc_pkg::LANG_EN;
    for (int p = 0; p < NPINS; p++) begin
      r.func[p] = (p == 0) ? lc_pkg::FN_TEACH_IN : lc_pkg::FN_AREA_OUT;
      r.b_start[p] = `BEAM_START_RST;
      r.b_end[p] = `BEAM_END_RST;
    end
    r.depth = `DEPTH_RST;
    r.vis = lc_pkg::VIS_NORMAL;
    r.tu = `TU_RST;
    r.dyn_lvl = 2'h3;
    return r;
  endfunction

  // constant reset image, so the reset branch loads a plain constant
  localparam core_t RST_VAL = rst_val();

  // byte address of a per-pin register
  function automatic logic [7:0] pin_ofs(input logic [7:0] base, input int p);
    return base + 8'(4 * p);
  endfunction

  // and/or evaluation of the beams between two beam numbers
  function automatic logic area_hit(input logic [NBEAMS-1:0] b, input logic [10:0] s,
                                    input logic [10:0] e, input logic any);
    logic [10:0] lo;
    logic [10:0] hi;
    logic all_i;
    logic any_i;
    logic seen;
    lo = (s < e) ? s : e;
    hi = (s < e) ? e : s;
    all_i = 1'b1;
    any_i = 1'b0;
    seen = 1'b0;
    for (int k = 0; k < NBEAMS; k++) begin
      if (11'(k + 1) >= lo && 11'(k + 1) <= hi) begin
        seen = 1'b1;
        all_i = all_i & b[k];
        any_i = any_i | b[k];
      end
    end
    return any ? any_i : (all_i && seen);
  endfunction

  // number of the lowest or highest interrupted beam, zero if none
  function automatic logic [10:0] edge_beam(input logic [NBEAMS-1:0] b, input logic top);
    logic [10:0] r;
    r = 11'h000;
    for (int k = 0; k < NBEAMS; k++) begin
      if (b[k] && (top || r == 11'h000)) r = 11'(k + 1);
    end
    return r;
  endfunction

  logic [1:0] rst_sync;
  logic rst_n;
  core_t st, next_st;
  logic [NBEAMS-1:0] f_beams;
  logic f_stable;
  logic [NPINS-1:0] teach_en;
  logic [NPINS-1:0] teach_lvl;
  logic [31:0] rd_word;
  logic addr_hit;
  logic acc;
  logic wr;
  logic tick;

  // reset release through two flops
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) rst_sync <= 2'h0;
    else rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // beam stability filter
  beam_filter #(.NB(NBEAMS)) u_filter (
    .i_mclk(i_mclk),
    .i_rst_n(rst_n),
    .i_strobe(i_meas_strobe),
    .i_beams(i_beams),
    .i_depth(st.depth),
    .o_beams(f_beams),
    .o_stable(f_stable)
  );

  // teach pulse width check per pin
  for (genvar g = 0; g < NPINS; g++) begin : g_teach
    assign teach_en[g] = st.func[g] == lc_pkg::FN_TEACH_IN;
    assign teach_lvl[g] = i_pin[g] ^ st.sinking;
    pulse_window #(.MIN_CYC(TEACH_MIN_CYC), .MAX_CYC(TEACH_MAX_CYC)) u_pw (
      .i_mclk(i_mclk),
      .i_rst_n(rst_n),
      .i_en(teach_en[g]),
      .i_level(teach_lvl[g]),
      .o_fire(o_teach_req[g])
    );
  end

  // apb handshake: no wait cycle, reply in the access phase
  assign acc = i_psel && i_penable;
  assign wr = acc && i_pwrite;
  assign tick = st.sec_div == 32'(SEC_CYC - 1);

  // read decode
  always_comb begin
    rd_word = 32'h0000_0000;
    addr_hit = 1'b1;
    if (i_paddr == `OFS_CTRL) begin
      rd_word[`CTRL_SINK_BIT] = st.sinking;
      rd_word[`CTRL_CASC_BIT] = st.casc;
      rd_word[`CTRL_LANG_LSB +: 3] = st.lang;
    end else if (i_paddr == `OFS_FILTER) begin
      rd_word[7:0] = st.depth;
    end else if (i_paddr == `OFS_DISP) begin
      rd_word[2:0] = st.vis;
      rd_word[`DISP_TU_LSB +: 9] = st.tu;
    end else if (i_paddr == `OFS_STATUS) begin
      rd_word[5:0] = {st.rejected, st.level, st.img_inv, st.cfg, f_stable};
    end else if (i_paddr == `OFS_INFO_ID) begin
      rd_word = PRODUCT_ID;
    end else if (i_paddr == `OFS_INFO_SN) begin
      rd_word = SERIAL_NO;
    end else if (i_paddr == `OFS_INFO_NAME) begin
      rd_word = PRODUCT_NAME;
    end else begin
      addr_hit = 1'b0;
    end
    for (int p = 0; p < NPINS; p++) begin
      if (i_paddr == pin_ofs(`OFS_PIN_CFG0, p)) begin
        addr_hit = 1'b1;
        rd_word[2:0] = st.func[p];
        rd_word[`PIN_INV_BIT] = st.inv[p];
        rd_word[`PIN_OR_BIT] = st.area_or[p];
      end
      if (i_paddr == pin_ofs(`OFS_PIN_BEAM0, p)) begin
        addr_hit = 1'b1;
        rd_word[10:0] = st.b_start[p];
        rd_word[`BEAM_END_LSB +: 11] = st.b_end[p];
      end
    end
  end

  // next state of registers, pins and display
  always_comb begin
    logic act;
    logic is_out;
    logic lin;
    logic [10:0] bs;
    logic [10:0] be;
    logic [8:0] acc3;
    act = 1'b0;
    is_out = 1'b0;
    lin = 1'b0;
    bs = i_pwdata[10:0];
    be = i_pwdata[`BEAM_END_LSB +: 11];
    acc3 = st.dyn_acc + 9'h003;
    next_st = st;
    if (i_psel && !i_penable) next_st.rdata = rd_word;
    // register writes, each field checked before it is taken
    if (wr && i_paddr == `OFS_CTRL) begin
      if (i_pwdata[`CTRL_LANG_LSB +: 3] > 3'h4) begin
        next_st.rejected = 1'b1;
      end else begin
        next_st.rejected = 1'b0;
        next_st.sinking = i_pwdata[`CTRL_SINK_BIT];
        next_st.casc = i_pwdata[`CTRL_CASC_BIT];
        next_st.lang = lc_pkg::lang_t'(i_pwdata[`CTRL_LANG_LSB +: 3]);
      end
    end
    for (int p = 0; p < NPINS; p++) begin
      if (wr && i_paddr == pin_ofs(`OFS_PIN_CFG0, p)) begin
        if (i_pwdata[2:0] > 3'h4) begin
          next_st.rejected = 1'b1;
        end else begin
          next_st.rejected = 1'b0;
          next_st.func[p] = lc_pkg::pin_func_t'(i_pwdata[2:0]);
          next_st.inv[p] = i_pwdata[`PIN_INV_BIT];
          next_st.area_or[p] = i_pwdata[`PIN_OR_BIT];
          if (i_pwdata[`PIN_TEACH_BIT] && edge_beam(f_beams, 1'b0) != 11'h000) begin
            next_st.b_start[p] = edge_beam(f_beams, 1'b0);
            next_st.b_end[p] = edge_beam(f_beams, 1'b1);
          end
        end
      end
      if (wr && i_paddr == pin_ofs(`OFS_PIN_BEAM0, p)) begin
        if (bs > `BEAM_MAX || be > `BEAM_MAX) begin
          next_st.rejected = 1'b1;
        end else begin
          next_st.rejected = 1'b0;
          next_st.b_start[p] = bs;
          next_st.b_end[p] = be;
        end
      end
    end
    if (wr && i_paddr == `OFS_FILTER) begin
      if (i_pwdata[8:0] > `DEPTH_MAX) begin
        next_st.rejected = 1'b1;
      end else begin
        next_st.rejected = 1'b0;
        next_st.depth = i_pwdata[7:0];
      end
    end
    if (wr && i_paddr == `OFS_DISP) begin
      if (i_pwdata[2:0] > 3'h4 || i_pwdata[`DISP_TU_LSB +: 9] < `TU_MIN
          || i_pwdata[`DISP_TU_LSB +: 9] > `TU_MAX) begin
        next_st.rejected = 1'b1;
      end else begin
        next_st.rejected = 1'b0;
        next_st.vis = lc_pkg::vis_t'(i_pwdata[2:0]);
        next_st.tu = i_pwdata[`DISP_TU_LSB +: 9];
        next_st.dyn_lvl = 2'h3;
        next_st.dyn_acc = 9'h000;
        next_st.burn_s = 10'h000;
        next_st.img_inv = 1'b0;
      end
    end
    // switching pins: function, inversion, then polarity
    for (int p = 0; p < NPINS; p++) begin
      unique case (st.func[p])
        lc_pkg::FN_AREA_OUT: begin
          is_out = 1'b1;
          act = area_hit(f_beams, st.b_start[p], st.b_end[p], st.area_or[p]);
        end
        lc_pkg::FN_WARN_OUT: begin
          is_out = 1'b1;
          act = i_warn;
        end
        lc_pkg::FN_TRIG_OUT: begin
          is_out = 1'b1;
          act = st.casc && i_trig_evt;
        end
        default: begin
          is_out = 1'b0;
          act = 1'b0;
        end
      endcase
      next_st.pin_oe[p] = is_out;
      next_st.pin[p] = is_out && (act ^ st.inv[p] ^ st.sinking);
      lin = i_pin[p] ^ st.sinking;
      next_st.lin_prev[p] = lin;
      next_st.trig_in[p] = st.casc && st.func[p] == lc_pkg::FN_TRIG_IN
                           && lin && !st.lin_prev[p];
    end
    // seconds timebase, configuration idle and dimming
    next_st.sec_div = tick ? 32'h0 : st.sec_div + 32'h1;
    if (i_button) begin
      next_st.cfg = 1'b1;
      next_st.wake = 1'b1;
      next_st.idle_s = 9'h000;
      next_st.dyn_lvl = 2'h3;
      next_st.dyn_acc = 9'h000;
    end else if (tick) begin
      if (st.idle_s != 9'(CFG_IDLE_S)) next_st.idle_s = st.idle_s + 9'h001;
      if (st.cfg && st.idle_s == 9'(CFG_IDLE_S - 1)) begin
        next_st.cfg = 1'b0;
        next_st.wake = 1'b0;
      end
      if (st.vis == lc_pkg::VIS_DYNAMIC && st.dyn_lvl != 2'h0) begin
        if (acc3 >= st.tu) begin
          next_st.dyn_acc = acc3 - st.tu;
          next_st.dyn_lvl = st.dyn_lvl - 2'h1;
        end else begin
          next_st.dyn_acc = acc3;
        end
      end
    end
    // burn-in protection for the fixed levels
    if (st.vis == lc_pkg::VIS_DARK || st.vis == lc_pkg::VIS_NORMAL
        || st.vis == lc_pkg::VIS_BRIGHT) begin
      if (tick) begin
        if (st.burn_s == 10'(BURN_S - 1)) begin
          next_st.burn_s = 10'h000;
          next_st.img_inv = !st.img_inv;
        end else begin
          next_st.burn_s = st.burn_s + 10'h001;
        end
      end
    end else begin
      next_st.burn_s = 10'h000;
      next_st.img_inv = 1'b0;
    end
    // brightness shown for the visibility setting
    unique case (st.vis)
      lc_pkg::VIS_OFF: next_st.level = st.wake ? 2'h2 : 2'h0;
      lc_pkg::VIS_DARK: next_st.level = 2'h1;
      lc_pkg::VIS_NORMAL: next_st.level = 2'h2;
      lc_pkg::VIS_BRIGHT: next_st.level = 2'h3;
      lc_pkg::VIS_DYNAMIC: next_st.level = st.dyn_lvl;
      default: next_st.level = 2'h0;
    endcase
  end

  // state register
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) st <= RST_VAL;
    else st <= next_st;
  end

  // outputs
  assign o_prdata = st.rdata;
  assign o_pready = acc;
  assign o_pslverr = acc && !addr_hit;
  assign o_pin = st.pin;
  assign o_pin_oe = st.pin_oe;
  assign o_trig_in = st.trig_in;
  assign o_disp_level = st.level;
  assign o_disp_invert = st.img_inv;
  assign o_cfg_mode = st.cfg;
  assign o_language = st.lang;

  default clocking @(posedge i_mclk); endclocking
  default disable iff (!rst_n);

  trig_gate_a: assert property (
    (!st.casc && st.func[0] == lc_pkg::FN_TRIG_OUT) |=> o_pin[0] == $past(st.inv[0] ^ st.sinking))
    else $error("trigger output active without cascading");
  input_release_a: assert property (
    (st.func[0] == lc_pkg::FN_TRIG_IN || st.func[0] == lc_pkg::FN_TEACH_IN) |=> !o_pin_oe[0])
    else $error("input pin driven");
  depth_reject_a: assert property (
    (wr && i_paddr == `OFS_FILTER && i_pwdata[8:0] > `DEPTH_MAX) |=> $stable(st.depth) && st.rejected)
    else $error("filter depth above limit accepted");
  beam_reject_a: assert property (
    (wr && i_paddr == `OFS_PIN_BEAM0 && i_pwdata[10:0] > `BEAM_MAX) |=> $stable(st.b_start[0]))
    else $error("start beam above limit accepted");
  unit_reject_a: assert property (
    (wr && i_paddr == `OFS_DISP && i_pwdata[`DISP_TU_LSB +: 9] > `TU_MAX) |=> $stable(st.tu))
    else $error("time unit above limit accepted");
  cfg_exit_a: assert property (
    (st.cfg && tick && !i_button && st.idle_s == 9'(CFG_IDLE_S - 1)) |=> !o_cfg_mode)
    else $error("configuration mode kept after idle time");
  off_blank_a: assert property (
    (st.vis == lc_pkg::VIS_OFF && !st.wake) |=> o_disp_level == 2'h0)
    else $error("display lit while off");
  burn_flip_a: assert property (
    (tick && st.vis == lc_pkg::VIS_NORMAL && st.burn_s == 10'(BURN_S - 1) && !wr)
    |=> o_disp_invert != $past(o_disp_invert))
    else $error("image not inverted after burn-in time");
  dyn_start_a: assert property (
    (i_button && st.vis == lc_pkg::VIS_DYNAMIC && !wr) |-> ##2 o_disp_level == 2'h3)
    else $error("dynamic dimming did not restart bright");
endmodule // io_cfg_core

// ===== rtl/io_cfg_regs.svh
`ifndef IO_CFG_REGS_SVH
`define IO_CFG_REGS_SVH
// Functional notes
// - one polarity setting for every pin
// - each pin takes exactly one function
// - trigger pins idle unless cascading enabled
// - height teach sets pin beam range
// - per-pin inversion gives dark switching
// - evaluate beams after depth consistent cycles
// - filter depth above 255 rejected, kept
// - inversion and depth writable over bus
// - five display visibility levels
// - visibility off stays blank until press
// - dynamic dims bright to off over time
// - time unit 1 to 240, else rejected
// - five idle minutes leave configuration mode
// - static brightness inverts image every 15 minutes
// - five selectable interface languages
// - read-only product name, part, serial
// - beam numbers above 1774 rejected

// clock rate
`define CLK_HZ 20000000
// register byte offsets
`define OFS_CTRL 8'h00
`define OFS_PIN_CFG0 8'h04
`define OFS_PIN_BEAM0 8'h0C
`define OFS_FILTER 8'h14
`define OFS_DISP 8'h18
`define OFS_STATUS 8'h1C
`define OFS_INFO_ID 8'h20
`define OFS_INFO_SN 8'h24
`define OFS_INFO_NAME 8'h28
// field positions
`define CTRL_SINK_BIT 0
`define CTRL_CASC_BIT 1
`define CTRL_LANG_LSB 2
`define PIN_INV_BIT 3
`define PIN_OR_BIT 4
`define PIN_TEACH_BIT 8
`define BEAM_END_LSB 16
`define DISP_TU_LSB 8
// limits and reset values
`define BEAM_MAX 11'h6EE
`define DEPTH_MAX 9'h0FF
`define TU_MIN 9'h001
`define TU_MAX 9'h0F0
`define DEPTH_RST 8'h01
`define TU_RST 9'h00A
`define BEAM_START_RST 11'h001
`define BEAM_END_RST 11'h020
// times
`define TEACH_MIN_MS 20
`define TEACH_MAX_MS 80
`define CFG_IDLE_MIN 5
`define BURN_MIN 15
`endif

// ===== rtl/lc_pkg.sv
package lc_pkg;
  typedef enum logic [2:0] {FN_TRIG_IN = 3'h0, FN_TEACH_IN = 3'h1, FN_AREA_OUT = 3'h2,
    FN_WARN_OUT = 3'h3, FN_TRIG_OUT = 3'h4} pin_func_t;
  typedef enum logic [2:0] {VIS_OFF = 3'h0, VIS_DARK = 3'h1, VIS_NORMAL = 3'h2,
    VIS_BRIGHT = 3'h3, VIS_DYNAMIC = 3'h4} vis_t;
  typedef enum logic [2:0] {LANG_EN = 3'h0, LANG_DE = 3'h1, LANG_FR = 3'h2,
    LANG_IT = 3'h3, LANG_ES = 3'h4} lang_t;
  typedef enum logic {PW_IDLE = 1'b0, PW_HIGH = 1'b1} pw_state_t;
  typedef struct packed {
    pw_state_t state;
    logic [31:0] cnt;
    logic fire;
  } pw_reg_t;
endpackage

// ===== rtl/pulse_window.sv
`timescale 1ns/1ps
module pulse_window #(
  parameter int MIN_CYC = 400000,
  parameter int MAX_CYC = 1600000
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // level to measure
  input wire logic i_en,
  input wire logic i_level,
  // accepted pulse
  output logic o_fire
);
  lc_pkg::pw_reg_t st, next_st;

  // time the high phase, accept only strictly inside the window
  always_comb begin
    next_st = st;
    next_st.fire = 1'b0;
    unique case (st.state)
      lc_pkg::PW_IDLE: begin
        next_st.cnt = 32'h1;
        if (i_en && i_level) next_st.state = lc_pkg::PW_HIGH;
      end
      lc_pkg::PW_HIGH: begin
        if (!i_en) begin
          next_st.state = lc_pkg::PW_IDLE;
        end else if (i_level) begin
          if (st.cnt < 32'(MAX_CYC)) next_st.cnt = st.cnt + 32'h1;
        end else begin
          next_st.fire = (st.cnt > 32'(MIN_CYC)) && (st.cnt < 32'(MAX_CYC));
          next_st.state = lc_pkg::PW_IDLE;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) st <= '0;
    else st <= next_st;
  end

  assign o_fire = st.fire;

  teach_window_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    o_fire |-> ($past(st.cnt) > 32'(MIN_CYC)) && ($past(st.cnt) < 32'(MAX_CYC)))
    else $error("teach pulse accepted outside window");
endmodule // pulse_window

// ===== rtl/beam_filter.sv
`timescale 1ns/1ps
module beam_filter #(
  parameter int NB = 32
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // raw beam states per measurement cycle
  input wire logic i_strobe,
  input wire logic [NB-1:0] i_beams,
  input wire logic [7:0] i_depth,
  // evaluated beam states
  output logic [NB-1:0] o_beams,
  output logic o_stable
);
  typedef struct packed {
    logic [NB-1:0] prev;
    logic [NB-1:0] beams;
    logic [7:0] run;
    logic stable;
  } filt_t;
  filt_t st, next_st;

  // count identical cycles, pass beams once the run reaches the depth
  always_comb begin
    next_st = st;
    if (i_strobe) begin
      if (i_beams != st.prev) begin
        next_st.prev = i_beams;
        next_st.run = 8'h01;
      end else if (st.run != 8'hFF) begin
        next_st.run = st.run + 8'h01;
      end
      next_st.stable = next_st.run >= i_depth;
      if (next_st.stable) next_st.beams = i_beams;
    end
  end

  // state register
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) st <= '0;
    else st <= next_st;
  end

  assign o_beams = st.beams;
  assign o_stable = st.stable;

  change_hold_a: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_strobe && i_beams != st.prev && i_depth > 8'h01) |=> $stable(o_beams) && !o_stable)
    else $error("beams passed on a changed cycle");
endmodule // beam_filter

// ===== testbench/plc_model.sv
`timescale 1ns/1ps
module plc_model (
  // clock
  input wire logic i_mclk,
  // polarity in use on the lines
  input wire logic i_sinking,
  // levels driven by the controller
  output logic [1:0] o_line
);
  logic [1:0] act = 2'h0;
  // idle level follows the polarity setting
  assign o_line = act ^ {2{i_sinking}};
  // hold one line active for w cycles
  task automatic pulse(input int p, input int w);
    act[p] <= 1'b1;
    repeat (w) @(posedge i_mclk);
    act[p] <= 1'b0;
    @(posedge i_mclk);
  endtask
endmodule // plc_model

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  localparam logic [31:0] pid = 32'h0000_5A5A; // arbitrary value
  localparam logic [31:0] sn = 32'h0000_0042; // arbitrary value
  localparam logic [31:0] pname = 32'h0000_7E57; // arbitrary value
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, beams = 32'h0;
  logic pready, pslverr, invert, cfg, sink = 1'b0;
  logic strobe = 1'b0, warn = 1'b0, trig_evt = 1'b0, button = 1'b0;
  logic [1:0] pin_w, pin_o, pin_oe, line, teach_req, trig_in, level;
  logic [2:0] lang;
  int fails = 0, checks_done = 0, teach_cnt = 0, trig_cnt = 0;
  // clock and wire level of the shared lines
  always #25 mclk = ~mclk;
  assign pin_w = (pin_o & pin_oe) | (line & ~pin_oe);
  // count pin event pulses
  always @(posedge mclk) begin
    if (teach_req[0] === 1'b1) teach_cnt++;
    if (trig_in[0] === 1'b1) trig_cnt++;
  end
  io_cfg_core #(.SEC_CYC(20), .TEACH_MIN_CYC(4), .TEACH_MAX_CYC(16), .PRODUCT_ID(pid),
    .SERIAL_NO(sn), .PRODUCT_NAME(pname)) io_cfg_core_i (.i_mclk(mclk), .i_arst_n(arst_n),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
    .i_meas_strobe(strobe), .i_beams(beams), .i_warn(warn), .i_trig_evt(trig_evt),
    .i_pin(pin_w), .o_pin(pin_o), .o_pin_oe(pin_oe), .o_teach_req(teach_req),
    .o_trig_in(trig_in), .i_button(button), .o_disp_level(level),
    .o_disp_invert(invert), .o_cfg_mode(cfg), .o_language(lang));
  plc_model plc_model_i (.i_mclk(mclk), .i_sinking(sink), .o_line(line));
  // verdict and end of run
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // compare and report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer, bounded wait on pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (n >= 16) begin
      fails++;
      end_sim();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFF_FFFF);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q & m, e);
  endtask
  task automatic meas(input logic [31:0] b, input int k);
    repeat (k) begin
      beams <= b;
      strobe <= 1'b1;
      @(posedge mclk);
      strobe <= 1'b0;
      @(posedge mclk);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // main sequence
  initial begin
    cyc(12);
    arst_n <= 1'b1;
    cyc(3);
    rd(8'h00, 32'h0);
    rd(8'h04, 32'h1);
    rd(8'h10, 32'h0020_0001);
    rd(8'h18, 32'h0000_0A02);
    rd(8'h20, pid);
    rd(8'h24, sn);
    wr(8'h28, 32'h0);
    rd(8'h28, pname);
    rd(8'h30, 32'h0);
    chk({31'h0, err}, 32'h1);
    $display("test reset and map done");
    wr(8'h14, 32'h100);
    rd(8'h14, 32'h1);
    rd(8'h1C, 32'h20, 32'h20);
    wr(8'h14, 32'hFF);
    rd(8'h14, 32'hFF);
    wr(8'h0C, 32'h0001_06EF);
    rd(8'h0C, 32'h0020_0001);
    wr(8'h0C, 32'h06EE_0001);
    rd(8'h0C, 32'h06EE_0001);
    wr(8'h18, 32'h0000_0002);
    wr(8'h18, 32'h0000_F102);
    rd(8'h18, 32'h0000_0A02);
    wr(8'h18, 32'h0000_F002);
    rd(8'h18, 32'h0000_F002);
    for (int l = 0; l < 5; l++) begin
      wr(8'h00, l << 2);
      rd(8'h00, l << 2);
      chk(lang, l);
    end
    wr(8'h00, 32'h14);
    rd(8'h00, 32'h10);
    wr(8'h04, 32'h5);
    rd(8'h04, 32'h1);
    wr(8'h00, 32'h0);
    $display("test limits done");
    wr(8'h14, 32'h3);
    meas(32'hFFFF_FFFF, 2);
    meas(32'h0, 1);
    meas(32'hFFFF_FFFF, 2);
    cyc(3);
    chk(pin_o[1], 32'h0);
    meas(32'hFFFF_FFFF, 1);
    cyc(3);
    chk(pin_o[1], 32'h1);
    wr(8'h08, 32'hA);
    cyc(2);
    chk(pin_o[1], 32'h0);
    sink <= 1'b1;
    wr(8'h00, 32'h1);
    cyc(2);
    chk(pin_o[1], 32'h1);
    sink <= 1'b0;
    wr(8'h00, 32'h0);
    wr(8'h08, 32'h2);
    meas(32'h0000_0F00, 3);
    wr(8'h08, 32'h102);
    cyc(3);
    rd(8'h10, 32'h000C_0009);
    rd(8'h08, 32'h2);
    chk(pin_o[1], 32'h1);
    $display("test filter and area done");
    teach_cnt = 0;
    plc_model_i.pulse(0, 2);
    cyc(4);
    plc_model_i.pulse(0, 8);
    cyc(4);
    plc_model_i.pulse(0, 30);
    cyc(4);
    chk(teach_cnt, 32'h1);
    wr(8'h04, 32'h0);
    trig_cnt = 0;
    plc_model_i.pulse(0, 3);
    cyc(4);
    chk(trig_cnt, 32'h0);
    wr(8'h00, 32'h2);
    plc_model_i.pulse(0, 3);
    cyc(4);
    chk(trig_cnt, 32'h1);
    trig_evt <= 1'b1;
    wr(8'h04, 32'h4);
    cyc(2);
    chk(pin_o[0], 32'h1);
    wr(8'h00, 32'h0);
    cyc(2);
    chk(pin_o[0], 32'h0);
    wr(8'h04, 32'h3);
    warn <= 1'b1;
    cyc(2);
    chk(pin_o[0], 32'h1);
    chk(pin_oe, 32'h3);
    $display("test pins done");
    wr(8'h18, 32'h0000_0304);
    cyc(2);
    chk(level, 32'h3);
    cyc(100);
    chk(level, 32'h0);
    wr(8'h18, 32'h0000_0A00);
    cyc(3);
    chk(level, 32'h0);
    button <= 1'b1;
    cyc(1);
    button <= 1'b0;
    cyc(3);
    chk(level, 32'h2);
    chk(cfg, 32'h1);
    cyc(6100);
    chk(cfg, 32'h0);
    wr(8'h18, 32'h0000_0A01);
    cyc(3);
    chk(level, 32'h1);
    chk(invert, 32'h0);
    cyc(18100);
    chk(invert, 32'h1);
    $display("test display done");
    end_sim();
  end
endmodule // tb_top
